// ==== pkg/cvrb_pkg.sv ====
/*
  Constants, field layouts and carrier types of the coil-voltage readback block.
  Assumes one 50 MHz system clock shared by the ADC averaging front end, the
  phase counter and the frame decoder that issues register reads.
*/
package cvrb_pkg;

  // ---------------------------------------------------------------------------
  // widths
  // ---------------------------------------------------------------------------
  localparam int unsigned CODE_W = 10;
  localparam int unsigned PHASE_W = 6;
  localparam int unsigned ADDR_W = 6;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned RSVD_W = 5;
  localparam int unsigned NUM_SLOTS = 2;

  // ---------------------------------------------------------------------------
  // register map and field positions
  // ---------------------------------------------------------------------------
  localparam logic [ADDR_W-1:0] ADDR_CV90 = 6'h0a;
  localparam logic [ADDR_W-1:0] ADDR_CV180 = 6'h0b;
  localparam int unsigned FIELD_LSB = 1;
  localparam int unsigned FIELD_MSB = 10;
  localparam int unsigned RSVD_LSB = 11;
  localparam int unsigned PARITY_BIT = 0;
  localparam logic [CODE_W-1:0] RESULT_RST = 10'h000;
  localparam logic [DATA_W-1:0] DATA_NONE = 16'h0000;

  // ---------------------------------------------------------------------------
  // capture points and scaling
  // ---------------------------------------------------------------------------
  localparam logic [PHASE_W-1:0] PHASE_90 = 6'h10;
  localparam logic [PHASE_W-1:0] PHASE_180 = 6'h20;
  localparam int unsigned FULL_SCALE_MV = 28000;
  localparam logic [CODE_W-1:0] CODE_FS = 10'h3ff;

  // ---------------------------------------------------------------------------
  // averaging
  // ---------------------------------------------------------------------------
  localparam int unsigned AVG_LOG2 = 2;
  localparam int unsigned SUM_W = CODE_W + AVG_LOG2;
  localparam logic [AVG_LOG2:0] AVG_CNT = 3'h4;
  localparam logic [AVG_LOG2:0] CNT_ZERO = 3'h0;
  localparam logic [SUM_W-1:0] SUM_ZERO = 12'h000;

  // averaged measurement tagged with the step it belongs to
  typedef struct packed {
    logic [PHASE_W-1:0] phase;
    logic [CODE_W-1:0] code;
  } cvrb_meas_type;

  // read-back word layout
  typedef struct packed {
    logic [RSVD_W-1:0] rsvd;
    logic [CODE_W-1:0] value;
    logic parity;
  } cvrb_word_type;

  // odd parity over the fifteen upper bits
  function automatic logic cvrb_parity(input logic [DATA_W-1:1] bits);
    cvrb_parity = ~(^bits);
  endfunction

endpackage : cvrb_pkg

// ==== src/cvrb_avg.sv ====
/*
  Per-step averager: sums a fixed number of ADC samples after each phase
  change and emits one tagged mean. Assumes ADC samples and phase counter
  come from logic on the same clock, so no synchroniser is needed.
*/
module cvrb_avg
  import cvrb_pkg::*;
(
  // clock, reset, enable
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic ce_i,
  // measurement input
  input wire logic samp_valid_i,
  input wire logic [CODE_W-1:0] samp_i,
  input wire logic [PHASE_W-1:0] phase_i,
  // averaged result
  output logic avg_valid_o,
  output cvrb_meas_type avg_o
);

  typedef enum logic [1:0] {
    ST_WAIT = 2'b01,
    ST_ACC = 2'b10
  } cvrb_avg_state_type;

  cvrb_avg_state_type state_q, state_d;
  logic [PHASE_W-1:0] phase_q, phase_d;
  logic [SUM_W-1:0] sum_q, sum_d;
  logic [AVG_LOG2:0] cnt_q, cnt_d;
  logic valid_q, valid_d;
  cvrb_meas_type avg_q, avg_d;

  // ---------------------------------------------------------------------------
  // next state: a phase change mid-average restarts it, so a mean never mixes steps
  // ---------------------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    phase_d = phase_i;
    sum_d = sum_q;
    cnt_d = cnt_q;
    valid_d = 1'b0;
    avg_d = avg_q;
    if (phase_i != phase_q) begin
      state_d = ST_ACC;
      sum_d = SUM_ZERO;
      cnt_d = CNT_ZERO;
    end else begin
      unique case (state_q)
        ST_WAIT: begin
          state_d = ST_WAIT;
        end
        ST_ACC: begin
          if (samp_valid_i) begin
            sum_d = sum_q + SUM_W'(samp_i);
            cnt_d = cnt_q + 1'b1;
          end
          if (cnt_q == AVG_CNT) begin
            // mean is complete only now; partial sums never leave here
            valid_d = 1'b1;
            avg_d.phase = phase_q;
            avg_d.code = sum_q[SUM_W-1:AVG_LOG2];
            state_d = ST_WAIT;
          end
        end
      endcase
    end
  end

  // registers, frozen while the enable is low
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_q <= ST_WAIT;
      phase_q <= '0;
      sum_q <= SUM_ZERO;
      cnt_q <= CNT_ZERO;
      valid_q <= 1'b0;
      avg_q <= '0;
    end else if (ce_i) begin
      state_q <= state_d;
      phase_q <= phase_d;
      sum_q <= sum_d;
      cnt_q <= cnt_d;
      valid_q <= valid_d;
      avg_q <= avg_d;
    end
  end

  assign avg_valid_o = valid_q;
  assign avg_o = avg_q;

endmodule // cvrb_avg

// ==== src/cvrb_top.sv ====
/*
  Coil-voltage readback: holds the averaged 90 and 180 degree coil voltages
  and returns them on register reads. Assumes an upstream frame decoder on
  the same clock issues one-cycle read strobes and inserts the word into its
  reply; ADC and phase counter also run on this clock.
*/
// How it works
// - 90 degree result sits in bits 10..1, bits 15..11 zero, bit 0 parity.
// - 90 degree result loads the mean taken while phase counter is 16.
// - 180 degree result uses the same layout in its own register.
// - 180 degree result loads the mean taken while phase counter is 32.
// - code 1023 stands for 28 volts; ADC codes pass through unscaled.
// - 180 degree register sits at 0x0B, read-only, bits 15..1 reset zero.
module cvrb_top
  import cvrb_pkg::*;
(
  // clock, reset, enable
  input wire logic CLK_SYS_I,
  input wire logic RESET_N_I,
  input wire logic CE_I,
  // measurement front end
  input wire logic ADC_VALID_I,
  input wire logic [CODE_W-1:0] ADC_SAMPLE_I,
  input wire logic [PHASE_W-1:0] PHASE_CNT_I,
  // register read port
  input wire logic RD_STB_I,
  input wire logic [ADDR_W-1:0] RD_ADDR_I,
  output logic RD_ACK_O,
  output logic RD_HIT_O,
  output logic [DATA_W-1:0] RD_DATA_O
);

  // ---------------------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------------------
  localparam logic [PHASE_W-1:0] SLOT_PHASE [NUM_SLOTS] = '{PHASE_90, PHASE_180};

  logic avg_valid;
  cvrb_meas_type avg;
  logic [CODE_W-1:0] res_q [NUM_SLOTS];
  logic [CODE_W-1:0] res_d [NUM_SLOTS];
  logic ack_q, ack_d;
  logic hit_q, hit_d;
  logic [DATA_W-1:0] data_q, data_d;

  // slot index of a mapped address, and whether it is mapped at all
  function automatic logic addr_hit(input logic [ADDR_W-1:0] a);
    addr_hit = (a == ADDR_CV90) || (a == ADDR_CV180);
  endfunction

  function automatic logic addr_slot(input logic [ADDR_W-1:0] a);
    addr_slot = (a == ADDR_CV180);
  endfunction

  // assemble a read-back word with reserved bits zero and parity in bit 0
  function automatic logic [DATA_W-1:0] make_word(input logic [CODE_W-1:0] v);
    cvrb_word_type w;
    w.rsvd = '0;
    w.value = v;
    w.parity = 1'b0;
    w.parity = cvrb_parity(w[DATA_W-1:1]);
    make_word = w;
  endfunction

  // ---------------------------------------------------------------------------
  // averaging front end
  // ---------------------------------------------------------------------------
  cvrb_avg u_avg (
    .clk_i(CLK_SYS_I),
    .reset_n_i(RESET_N_I),
    .ce_i(CE_I),
    .samp_valid_i(ADC_VALID_I),
    .samp_i(ADC_SAMPLE_I),
    .phase_i(PHASE_CNT_I),
    .avg_valid_o(avg_valid),
    .avg_o(avg)
  );

  // ---------------------------------------------------------------------------
  // result registers
  // ---------------------------------------------------------------------------
  // the ADC already spans 0..28 V over the full code range, so no rescale
  // is done here; a gain trim would belong in the ADC, not the readback
  genvar g;
  generate
    for (g = 0; g < NUM_SLOTS; g++) begin : g_slot
      // load only on a finished mean for this slot's step
      always_comb begin
        res_d[g] = res_q[g];
        if (avg_valid && (avg.phase == SLOT_PHASE[g])) begin
          res_d[g] = avg.code;
        end
      end

      always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
          res_q[g] <= RESULT_RST;
        end else if (CE_I) begin
          res_q[g] <= res_d[g];
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------------------
  // read port
  // ---------------------------------------------------------------------------
  // no write path exists: both words are read-only by construction
  always_comb begin
    ack_d = RD_STB_I;
    hit_d = 1'b0;
    data_d = DATA_NONE;
    if (RD_STB_I && addr_hit(RD_ADDR_I)) begin
      hit_d = 1'b1;
      data_d = make_word(res_q[addr_slot(RD_ADDR_I)]);
    end
  end

  // read answer registered one cycle after the strobe
  always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      ack_q <= 1'b0;
      hit_q <= 1'b0;
      data_q <= DATA_NONE;
    end else if (CE_I) begin
      ack_q <= ack_d;
      hit_q <= hit_d;
      data_q <= data_d;
    end
  end

  assign RD_ACK_O = ack_q & CE_I;
  assign RD_HIT_O = hit_q;
  assign RD_DATA_O = data_q;

  // ---------------------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge CLK_SYS_I);
  endclocking
  default disable iff (!RESET_N_I);

  sequence s_load90;
    CE_I && avg_valid && (avg.phase == PHASE_90);
  endsequence

  sequence s_load180;
    CE_I && avg_valid && (avg.phase == PHASE_180);
  endsequence

  sequence s_read(logic [ADDR_W-1:0] a);
    CE_I && RD_STB_I && (RD_ADDR_I == a) ##1 CE_I;
  endsequence

  chk_load_ninety: assert property (
    s_load90 |=> (res_q[0] == $past(avg.code)))
    else $error("90 degree result missed its mean");

  chk_load_oneeighty: assert property (
    s_load180 |=> (res_q[1] == $past(avg.code)))
    else $error("180 degree result missed its mean");

  chk_hold_partial: assert property (
    !(CE_I && avg_valid) |=> $stable(res_q[0]) && $stable(res_q[1]))
    else $error("result changed without a complete mean");

  chk_read_ninety: assert property (
    s_read(ADDR_CV90) |-> RD_ACK_O && RD_HIT_O &&
      (RD_DATA_O[FIELD_MSB:FIELD_LSB] == $past(res_q[0])) &&
      (RD_DATA_O[DATA_W-1:RSVD_LSB] == '0))
    else $error("90 degree word layout wrong");

  chk_read_oneeighty: assert property (
    s_read(ADDR_CV180) |-> RD_ACK_O && RD_HIT_O &&
      (RD_DATA_O[FIELD_MSB:FIELD_LSB] == $past(res_q[1])))
    else $error("180 degree word layout wrong");

  chk_word_parity: assert property (
    RD_ACK_O && RD_HIT_O |-> (^RD_DATA_O) == 1'b1)
    else $error("read word parity not odd");

  // a full-scale 180 degree result must come back unscaled in the read field
  chk_full_scale: assert property (
    CE_I && RD_STB_I && (RD_ADDR_I == ADDR_CV180) && (res_q[1] == CODE_FS) |=>
      RD_DATA_O[FIELD_MSB:FIELD_LSB] == CODE_FS)
    else $error("full scale code not carried through");

  chk_reset_clear: assert property (
    $rose(RESET_N_I) |-> (res_q[1] == RESULT_RST) && (RD_DATA_O == DATA_NONE))
    else $error("180 degree result not zero after reset");

endmodule // cvrb_top

// ==== verification/cvrb_host.sv ====
/*
  Host-side read requester for the coil-voltage readback block.
  Assumes the one-cycle read strobe and registered answer of the read port.
*/
module cvrb_host
  import cvrb_pkg::*;
(
  // clock and answer
  input wire logic clk_i,
  input wire logic ack_i,
  input wire logic hit_i,
  input wire logic [DATA_W-1:0] data_i,
  // request
  output logic stb_o,
  output logic [ADDR_W-1:0] addr_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // -------------------------------------------------------------------------
  // read cycle
  // -------------------------------------------------------------------------
  initial begin
    stb_o = 1'b0;
    addr_o = 6'h3f;
  end

  // address shows its inverse once released, so a stale value never passes
  task automatic read(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d,
                      output logic h, output bit ok);
    ok = 1'b0;
    @(posedge clk_i);
    stb_o <= 1'b1;
    addr_o <= a;
    @(posedge clk_i);
    stb_o <= 1'b0;
    addr_o <= ~a;
    // the answer is taken at the rising edge that sees the ack high
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_i);
      if (ack_i === 1'b1) begin
        d = data_i;
        h = hit_i;
        ok = 1'b1;
        break;
      end
    end
  endtask
endmodule // cvrb_host

// ==== verification/tb_coil_voltage_readback.sv ====
/*
  Self-checking bench of the coil-voltage readback block.
  Assumes one 50 MHz clock; reads go through the host model.
*/
module tb_coil_voltage_readback
  import cvrb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  int keep [2];
  logic adc_valid = 1'b0;
  logic [CODE_W-1:0] adc_sample = 10'h000;
  logic [PHASE_W-1:0] phase_cnt = 6'h00;
  logic rd_stb, rd_ack, rd_hit;
  logic [ADDR_W-1:0] rd_addr;
  logic [DATA_W-1:0] rd_data;
  int errors = 0;
  int n_compared = 0;
  int res [2] = '{0, 0};
  int seed = 32'hb216f17f;

  // -------------------------------------------------------------------------
  // clock, design and host
  // -------------------------------------------------------------------------
  initial begin
    forever #10 clk = ~clk;
  end

  cvrb_top uut (.CLK_SYS_I(clk), .RESET_N_I(rst_n), .CE_I(ce),
    .ADC_VALID_I(adc_valid), .ADC_SAMPLE_I(adc_sample), .PHASE_CNT_I(phase_cnt),
    .RD_STB_I(rd_stb), .RD_ADDR_I(rd_addr), .RD_ACK_O(rd_ack), .RD_HIT_O(rd_hit),
    .RD_DATA_O(rd_data));

  cvrb_host host (.clk_i(clk), .ack_i(rd_ack), .hit_i(rd_hit), .data_i(rd_data),
    .stb_o(rd_stb), .addr_o(rd_addr));

  // -------------------------------------------------------------------------
  // model and checks
  // -------------------------------------------------------------------------
  // expected word: value in 10..1, upper bits zero, bit 0 makes the total odd
  function automatic logic [15:0] word(input int v);
    logic [15:0] w;
    w = {5'h00, v[9:0], 1'b0};
    w[0] = ~(^w[15:1]);
    return w;
  endfunction

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask

  task automatic rdchk(input logic [ADDR_W-1:0] a);
    logic [15:0] d, e;
    logic h;
    bit ok;
    host.read(a, d, h, ok);
    check({15'h0000, ok}, 16'h0001);
    e = (a == ADDR_CV90) ? word(res[0]) : (a == ADDR_CV180) ? word(res[1]) : DATA_NONE;
    check(d, e);
    check({15'h0000, h}, {15'h0000, a == ADDR_CV90 || a == ADDR_CV180});
  endtask

  // one step: phase change, n samples (code < 0 picks random), then settle
  task automatic meas(input logic [PHASE_W-1:0] ph, input int n, input int code);
    int sum, c;
    sum = 0;
    @(posedge clk);
    phase_cnt <= 6'h3f;
    @(posedge clk);
    phase_cnt <= ph;
    for (int i = 0; i < n; i++) begin
      c = (code < 0) ? ($random(seed) & 32'h3ff) : code;
      if (i < 4) sum += c;
      @(posedge clk);
      adc_valid <= 1'b1;
      adc_sample <= c[9:0];
    end
    @(posedge clk);
    adc_valid <= 1'b0;
    adc_sample <= ~adc_sample;
    repeat (3) @(posedge clk);
    if (n >= 4 && ph == PHASE_90) res[0] = sum / 4;
    if (n >= 4 && ph == PHASE_180) res[1] = sum / 4;
  endtask

  task automatic rd_all();
    rdchk(ADDR_CV90);
    rdchk(ADDR_CV180);
  endtask

  task automatic print_verdict();
    $display("compared %0d, mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // -------------------------------------------------------------------------
  // watchdog: the sequence needs well under 2000 cycles
  // -------------------------------------------------------------------------
  initial begin
    #200us;
    errors++;
    $display("unexpected at %0t: run hung", $time);
    print_verdict();
  end

  // -------------------------------------------------------------------------
  // scenarios
  // -------------------------------------------------------------------------
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    rd_all();
    rdchk(6'h09);
    rdchk(6'h3f);
    $display("test reset_and_map done");
    for (int k = 0; k < 4; k++) begin
      meas(PHASE_90, 4, -1);
      meas(PHASE_180, 4 + k, -1);
      rd_all();
    end
    $display("test capture done");
    meas(PHASE_180, 4, 1023);
    meas(PHASE_90, 4, 0);
    rd_all();
    $display("test full_scale done");
    meas(PHASE_90, 3, 500);
    meas(PHASE_180, 2, 7);
    meas(6'h11, 4, 300);
    meas(6'h30, 4, 300);
    rd_all();
    $display("test partial_and_other done");
    // a full four-sample step sent while the enable is low must leave results alone
    keep = res;
    @(posedge clk);
    ce <= 1'b0;
    meas(PHASE_90, 4, 900);
    ce <= 1'b1;
    res = keep;
    rd_all();
    $display("test enable_freeze done");
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    res = '{0, 0};
    rd_all();
    $display("test second_reset done");
    print_verdict();
  end
endmodule // tb_coil_voltage_readback
